// ---- logic/lmsc_defines.vh ----
`ifndef LMSC_DEFINES_VH
`define LMSC_DEFINES_VH

// Register indices on the function page.
`define LMSC_REG_CONFIG     8'h02
`define LMSC_REG_PULLDN1    8'h30
`define LMSC_REG_PULLDN2    8'h32
`define LMSC_REG_PULLUP1    8'h34
`define LMSC_REG_PULLUP2    8'h36
`define LMSC_REG_SWRESET    8'h3e

// Field positions.
`define LMSC_CFG_RUN_BIT    0
`define LMSC_HI_FIELD_MSB   6
`define LMSC_HI_FIELD_LSB   4
`define LMSC_LO_FIELD_MSB   3
`define LMSC_LO_FIELD_LSB   1
`define LMSC_SCALE_BIT      2

// Reset values.
`define LMSC_RST_BYTE       8'h00
`define LMSC_SWRESET_KEY    8'h00
`define LMSC_LEVEL_OFF      3'h0

// Register file size.
`define LMSC_NUM_REGS       6
`define LMSC_IDX_W          3

`endif

// ---- logic/lmsc_reg_mem.v ----
`timescale 1ns/1ps

// Small register store for the function page; read data come from a flop.
module lmsc_reg_mem (
	// Clock and reset
	input  wire       clk_sys_i,
	input  wire       rst_n_i,
	// Write port
	input  wire       we_i,
	input  wire [2:0] waddr_i,
	input  wire [7:0] wdata_i,
	input  wire       clear_i,
	// Read port
	input  wire [2:0] raddr_i,
	output reg  [7:0] rdata_o,
	// Whole contents, flattened
	output wire [47:0] all_o
);
	reg [7:0] mem_q [0:5];
	genvar g;

	// Each entry keeps its value until written or cleared, whatever the power state.
	generate
		for (g = 0; g < 6; g = g + 1) begin : g_ent
			always @(posedge clk_sys_i or negedge rst_n_i) begin
				if (!rst_n_i) begin
					mem_q[g] <= 8'h00;
				end else if (clear_i) begin
					mem_q[g] <= 8'h00;
				end else if (we_i && waddr_i == g) begin
					mem_q[g] <= wdata_i;
				end
			end
			assign all_o[g*8 +: 8] = mem_q[g];
		end
	endgenerate

	// Registered read; indices past the end read as zero.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rdata_o <= 8'h00;
		end else if (raddr_i < 3'd6) begin
			rdata_o <= mem_q[raddr_i];
		end else begin
			rdata_o <= 8'h00;
		end
	end
endmodule // lmsc_reg_mem

// ---- logic/lmsc_shutdown_ctrl.v ----
`timescale 1ns/1ps
`include "lmsc_defines.vh"

module lmsc_shutdown_ctrl (
	// Clock and reset
	input  wire        clk_sys_i,
	input  wire        rst_n_i,
	// Shutdown pin, asynchronous to the clock
	input  wire        shutdown_n_pin_i,
	// Register access from the serial interface, same clock
	input  wire        reg_wr_i,
	input  wire        reg_rd_i,
	input  wire [7:0]  reg_addr_i,
	input  wire [7:0]  reg_wdata_i,
	output reg  [7:0]  reg_rdata_o,
	output reg         reg_rvalid_o,
	// Serial interface reset request
	output reg         if_reset_o,
	// Power state
	output reg         hw_shutdown_o,
	output reg         sw_shutdown_o,
	output reg         blank_o,
	output reg         analog_en_o,
	// Matrix outputs
	output reg  [23:0] column_current_sink_en_o,
	output reg  [11:0] row_pulldown_level_o,
	output reg  [3:0]  pulldown_scale_select_o,
	output reg  [2:0]  column_pullup_level_o
);
	// Pin synchroniser; only the second stage feeds logic.
	reg         pin_s1_q;
	reg         pin_s2_q;
	reg         pin_prev_q;
	wire        rise;
	// Register port: decode, store and read handshake.
	reg         rd_pend_q;
	reg         idx_ok;
	reg  [2:0]  idx;
	wire [7:0]  mem_rdata;
	wire [47:0] regs;
	wire        sw_reset;
	wire        wr_ok;
	// Stored bytes that steer the outputs.
	wire [7:0]  cfg;
	wire [7:0]  pd1;
	wire [7:0]  pd2;
	wire [7:0]  pu1;
	wire [7:0]  pu2;
	wire [11:0] row_code;
	// Next values of the registered power state and matrix outputs.
	reg         if_reset_d;
	reg         hw_shutdown_d;
	reg         sw_shutdown_d;
	reg         blank_d;
	reg         analog_en_d;
	reg  [23:0] sink_en_d;
	reg  [11:0] row_level_d;
	reg  [3:0]  scale_d;
	reg  [2:0]  pullup_d;
	genvar      r;

	// Two flops bring the pin into the clock domain and a third keeps the last synchronised
	// level for edge detection. All three reset low, so a pin that is already high when
	// reset lifts gives one interface reset, which does no harm.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			pin_s1_q   <= 1'b0;
			pin_s2_q   <= 1'b0;
			pin_prev_q <= 1'b0;
		end else begin
			pin_s1_q   <= shutdown_n_pin_i;
			pin_s2_q   <= pin_s1_q;
			pin_prev_q <= pin_s2_q;
		end
	end

	// Low to high step of the synchronised pin, one cycle wide.
	assign rise = pin_s2_q & ~pin_prev_q;

	// Address decode into the local store index. Unmapped addresses, the software reset
	// among them, leave idx_ok low, so they never write the store and read back as zero.
	always @* begin
		idx_ok = 1'b1;
		idx    = 3'd0;
		if (reg_addr_i == `LMSC_REG_CONFIG) begin
			idx = 3'd0;
		end else if (reg_addr_i == `LMSC_REG_PULLDN1) begin
			idx = 3'd1;
		end else if (reg_addr_i == `LMSC_REG_PULLDN2) begin
			idx = 3'd2;
		end else if (reg_addr_i == `LMSC_REG_PULLUP1) begin
			idx = 3'd3;
		end else if (reg_addr_i == `LMSC_REG_PULLUP2) begin
			idx = 3'd4;
		end else begin
			idx_ok = 1'b0;
		end
	end

	// Writes are taken in any power state; the edge cycle drops them as the host must not
	// be mid-transaction then anyway.
	assign wr_ok    = reg_wr_i & ~rise;
	assign sw_reset = wr_ok & (reg_addr_i == `LMSC_REG_SWRESET) &
	                  (reg_wdata_i == `LMSC_SWRESET_KEY);

	// Stored values are touched only by writes, the software reset and rst_n_i, never by shutdown.
	lmsc_reg_mem u_mem (
		.clk_sys_i (clk_sys_i),
		.rst_n_i   (rst_n_i),
		.we_i      (wr_ok & idx_ok),
		.waddr_i   (idx),
		.wdata_i   (reg_wdata_i),
		.clear_i   (sw_reset),
		.raddr_i   (idx_ok ? idx : 3'd7),
		.rdata_o   (mem_rdata),
		.all_o     (regs)
	);

	// Named views of the stored bytes.
	assign cfg = regs[7:0];
	assign pd1 = regs[15:8];
	assign pd2 = regs[23:16];
	assign pu1 = regs[31:24];
	assign pu2 = regs[39:32];

	// Read handshake: the store's read flop and rd_pend_q advance together, so the data is
	// in hand when valid rises. A read in the pin edge cycle is dropped and never answered.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			rd_pend_q    <= 1'b0;
			reg_rvalid_o <= 1'b0;
			reg_rdata_o  <= 8'h00;
		end else begin
			rd_pend_q    <= reg_rd_i & ~rise;
			reg_rvalid_o <= rd_pend_q;
			if (rd_pend_q) begin
				reg_rdata_o <= mem_rdata;
			end
		end
	end

	// Row codes, one generate step per row switch. Rows 0 and 1 share the first pull-down
	// byte and rows 2 and 3 the second; the even row of each pair sits in the upper field.
	generate
		for (r = 0; r < 4; r = r + 1) begin : g_row
			wire [7:0] src;
			assign src = (r < 2) ? pd1 : pd2;
			if ((r % 2) == 0) begin : g_hi
				assign row_code[r*3 +: 3] = src[`LMSC_HI_FIELD_MSB:`LMSC_HI_FIELD_LSB];
			end else begin : g_lo
				assign row_code[r*3 +: 3] = src[`LMSC_LO_FIELD_MSB:`LMSC_LO_FIELD_LSB];
			end
		end
	endgenerate

	// Next values. Blanking is the OR of both shutdown sources, so either one alone keeps
	// the sinks dark; the sinks need the run bit and the synchronised pin together. The
	// run bit is read from the store, so it survives any number of shutdown cycles.
	always @* begin
		if_reset_d    = rise;
		hw_shutdown_d = ~pin_s2_q;
		analog_en_d   = pin_s2_q;
		sw_shutdown_d = ~cfg[`LMSC_CFG_RUN_BIT];
		blank_d       = hw_shutdown_d | sw_shutdown_d;
		sink_en_d     = blank_d ? 24'h000000 : 24'hffffff;
		// The anti-ghost levels follow the store while the pin is high. With the pin low the
		// analogue side is off, so the outputs drop to zero while the stored codes stay put;
		// a host that skips clearing them before shutdown still sees no pull voltages.
		if (pin_s2_q) begin
			row_level_d = row_code;
			scale_d     = {4{pu2[`LMSC_SCALE_BIT]}};
			pullup_d    = pu1[`LMSC_HI_FIELD_MSB:`LMSC_HI_FIELD_LSB];
		end else begin
			row_level_d = 12'h000;
			scale_d     = 4'h0;
			pullup_d    = `LMSC_LEVEL_OFF;
		end
	end

	// Power state and output gating, all from flops so the matrix never sees decode
	// glitches. While reset is low the serial interface is held in reset as well, and the
	// device sits in both shutdowns until the pin and the run bit say otherwise.
	always @(posedge clk_sys_i or negedge rst_n_i) begin
		if (!rst_n_i) begin
			if_reset_o               <= 1'b1;
			hw_shutdown_o            <= 1'b1;
			sw_shutdown_o            <= 1'b1;
			blank_o                  <= 1'b1;
			analog_en_o              <= 1'b0;
			column_current_sink_en_o <= 24'h000000;
			row_pulldown_level_o     <= 12'h000;
			pulldown_scale_select_o  <= 4'h0;
			column_pullup_level_o    <= 3'h0;
		end else begin
			if_reset_o               <= if_reset_d;
			hw_shutdown_o            <= hw_shutdown_d;
			sw_shutdown_o            <= sw_shutdown_d;
			blank_o                  <= blank_d;
			analog_en_o              <= analog_en_d;
			column_current_sink_en_o <= sink_en_d;
			row_pulldown_level_o     <= row_level_d;
			pulldown_scale_select_o  <= scale_d;
			column_pullup_level_o    <= pullup_d;
		end
	end
endmodule // lmsc_shutdown_ctrl

// ---- tb/lmsc_chk.sv ----
`timescale 1ns/1ps
// Ties each power state output to the inputs or state that cause it.
module lmsc_chk (
	// Clock, reset, register strobes and the shutdown pin
	input wire        clk_sys_i,
	input wire        rst_n_i,
	input wire        reg_rd_i,
	input wire        reg_wr_i,
	input wire        shutdown_n_pin_i,
	// Observed outputs
	input wire        reg_rvalid_o,
	input wire        if_reset_o,
	input wire        hw_shutdown_o,
	input wire        sw_shutdown_o,
	input wire        blank_o,
	input wire        analog_en_o,
	input wire [23:0] column_current_sink_en_o,
	input wire [11:0] row_pulldown_level_o,
	input wire [3:0]  pulldown_scale_select_o,
	input wire [2:0]  column_pullup_level_o
);
	// One domain, so the clock and the reset are given once.
	default clocking @(posedge clk_sys_i); endclocking
	default disable iff (!rst_n_i);
	blank_or_a: assert property (blank_o == (hw_shutdown_o | sw_shutdown_o))
		else $error("blank wrong");
	sink_off_a: assert property (column_current_sink_en_o == {24{!blank_o}})
		else $error("sinks wrong");
	analog_off_a: assert property (analog_en_o != hw_shutdown_o)
		else $error("analog wrong");
	reset_pulse_a: assert property ($rose(if_reset_o) |=> !if_reset_o)
		else $error("reset pulse long");
	hw_exit_a: assert property ($fell(hw_shutdown_o) |-> if_reset_o)
		else $error("exit without reset");
	hw_follow_a: assert property (hw_shutdown_o == !$past(shutdown_n_pin_i, 3))
		else $error("hw state lags pin");
	deghost_off_a: assert property (hw_shutdown_o |-> {row_pulldown_level_o,
		pulldown_scale_select_o, column_pullup_level_o} == 19'h0) else $error("deghost on");
	read_answer_a: assert property (reg_rd_i |-> ##2 reg_rvalid_o)
		else $error("no read answer");
	valid_cause_a: assert property (reg_rvalid_o |-> $past(reg_rd_i, 2))
		else $error("stray valid");
	run_hold_a: assert property ($changed(sw_shutdown_o) |-> $past(reg_wr_i, 2))
		else $error("run state moved");
endmodule // lmsc_chk

bind lmsc_shutdown_ctrl lmsc_chk lmsc_chk_inst (.*);

// ---- tb/lmsc_host_model.sv ----
`timescale 1ns/1ps
// Host driver of the shutdown pin; the lag keeps pin edges off the clock edge.
module lmsc_host_model (
	// Request from the sequence
	input  wire pin_req_i,
	// Shutdown pin
	output wire shutdown_n_pin_o
);
	// The sequence keeps the register port quiet around each raise.
	assign #3 shutdown_n_pin_o = pin_req_i;
endmodule // lmsc_host_model

// ---- tb/tb.sv ----
`timescale 1ns/1ps
module tb;
	reg         clk_sys_i, rst_n_i, pin_req, reg_wr_i, reg_rd_i;
	reg  [7:0]  reg_addr_i, reg_wdata_i;
	wire [7:0]  reg_rdata_o;
	wire        reg_rvalid_o, if_reset_o, hw_shutdown_o, sw_shutdown_o;
	wire        blank_o, analog_en_o, shutdown_n_pin_i;
	wire [23:0] column_current_sink_en_o;
	wire [11:0] row_pulldown_level_o;
	wire [3:0]  pulldown_scale_select_o;
	wire [2:0]  column_pullup_level_o;
	integer     errors = 0, tests_run = 0, n;
	lmsc_shutdown_ctrl lmsc_shutdown_ctrl_inst (.*);
	lmsc_host_model lmsc_host_model_inst (.pin_req_i(pin_req),
		.shutdown_n_pin_o(shutdown_n_pin_i));
	// Free running 100 MHz clock.
	initial begin
		clk_sys_i = 1'b0;
		forever #5 clk_sys_i = ~clk_sys_i;
	end
	task chk(input string name, input [23:0] seen, input [23:0] exp);
		tests_run = tests_run + 1;
		if (seen !== exp) begin
			errors = errors + 1;
			$display("CHECK FAILED %0s exp %h seen %h", name, exp, seen);
		end
	endtask
	task give_verdict;
		$display("errors %0d tests_run %0d", errors, tests_run);
		if (errors == 0 && tests_run > 0) $display("bench passed");
		else $display("bench failed");
		$finish;
	endtask
	// Write strobe for one cycle, then let the store and outputs settle.
	task wr(input [7:0] a, input [7:0] d);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_wdata_i <= d;
		reg_wr_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_wr_i <= 1'b0;
		repeat (3) @(posedge clk_sys_i);
		#1;
	endtask
	// Read strobe for one cycle, bounded wait for the answer.
	task rd(input [7:0] a, input [7:0] exp);
		@(posedge clk_sys_i);
		reg_addr_i <= a;
		reg_rd_i <= 1'b1;
		@(posedge clk_sys_i);
		reg_rd_i <= 1'b0;
		#1;
		n = 0;
		while (reg_rvalid_o !== 1'b1 && n < 8) begin
			@(posedge clk_sys_i);
			#1;
			n = n + 1;
		end
		chk("rdata", {reg_rvalid_o, reg_rdata_o}, {1'b1, exp});
	endtask
	// Moves the pin and waits, bounded, for the synchronised state to follow.
	task pin(input v);
		pin_req = v;
		n = 0;
		while (hw_shutdown_o !== ~v && n < 20) begin
			@(posedge clk_sys_i);
			#1;
			n = n + 1;
		end
		chk("ifrst", {hw_shutdown_o, if_reset_o}, {~v, v});
		repeat (2) @(posedge clk_sys_i);
		#1;
	endtask
	initial begin
		#20000;
		errors = errors + 1;
		give_verdict;
	end
	initial begin
		{rst_n_i, pin_req, reg_wr_i, reg_rd_i} = 4'h0;
		reg_addr_i = 8'h00;
		reg_wdata_i = 8'h00;
		repeat (4) @(posedge clk_sys_i);
		rst_n_i <= 1'b1;
		rd(8'h02, 8'h00);
		chk("pwr", {sw_shutdown_o, hw_shutdown_o, blank_o, analog_en_o}, 4'he);
		wr(8'h30, 8'h36);
		wr(8'h32, 8'h48);
		wr(8'h34, 8'h50);
		wr(8'h36, 8'h00);
		wr(8'h02, 8'h01);
		rd(8'h30, 8'h36);
		chk("lvl", {row_pulldown_level_o, pulldown_scale_select_o, column_pullup_level_o}, 0);
		chk("pwr", {sw_shutdown_o, hw_shutdown_o, blank_o, analog_en_o}, 4'h6);
		pin(1'b1);
		chk("pwr", {sw_shutdown_o, hw_shutdown_o, blank_o, analog_en_o}, 4'h1);
		chk("sink", column_current_sink_en_o, 24'hffffff);
		chk("lvl", {row_pulldown_level_o, pulldown_scale_select_o, column_pullup_level_o},
			{12'h91b, 4'h0, 3'h5});
		wr(8'h30, 8'h5a);
		wr(8'h32, 8'h6c);
		wr(8'h34, 8'h20);
		wr(8'h36, 8'h04);
		chk("lvl", {row_pulldown_level_o, pulldown_scale_select_o, column_pullup_level_o},
			{12'hdad, 4'hf, 3'h2});
		wr(8'h02, 8'h00);
		chk("sink", column_current_sink_en_o, 24'h0);
		chk("pwr", {sw_shutdown_o, hw_shutdown_o, blank_o, analog_en_o}, 4'hb);
		rd(8'h10, 8'h00);
		wr(8'h3e, 8'h01);
		rd(8'h30, 8'h5a);
		wr(8'h3e, 8'h00);
		rd(8'h30, 8'h00);
		rd(8'h3e, 8'h00);
		pin(1'b0);
		chk("pwr", {sw_shutdown_o, hw_shutdown_o, blank_o, analog_en_o}, 4'he);
		give_verdict;
	end
endmodule // tb
